// >>> bench/gpio_status_properties.sv
// Checker: bus answer, lamp pattern and alarm pad properties
`timescale 1ns/1ps
`default_nettype none
module gpio_status_properties
    import gpio_status_pkg::*;
#(
    parameter longint FAST_PERIOD = FAST_PERIOD_CYC,
    parameter longint FAST_ON     = FAST_ON_CYC,
    parameter longint SLOW_PERIOD = SLOW_PERIOD_CYC,
    parameter longint SLOW_ON     = SLOW_ON_CYC
)
(
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic [ADDR_W-1:0]    avs_address,
    input wire logic                 avs_read,
    input wire logic                 avs_write,
    input wire logic [31:0]          avs_writedata,
    input wire logic                 avs_waitrequest,
    input wire logic [PAD_COUNT-1:0] pad_out,
    input wire logic [PAD_COUNT-1:0] pad_oe,
    input wire logic                 temp_limit_reached,
    input wire logic                 network_status_indicator
);
    // ------------------------------------------------------------
    // Shadow of lamp and alarm setup, pin run length
    // ------------------------------------------------------------
    logic [2:0]  lamp_r;
    logic [7:0]  temp_r;
    logic [3:0]  age_r;
    logic        prev_r;
    logic [31:0] run_r;
    wire logic   wr_ok = avs_write && !avs_waitrequest;
    wire logic   lamp_wr = wr_ok && avs_address == REG_LAMP_CTRL;
    wire logic   ind = network_status_indicator;
    wire logic   fast = !lamp_r[2] && lamp_r[1:0] == LAMP_SEARCHING;
    wire logic   slow = !lamp_r[2] && lamp_r[1:0] == LAMP_REGISTERED;
    wire logic   dark = !lamp_r[2] && (lamp_r[1:0] == LAMP_OFF || lamp_r[1:0] == 2'h3);
    always_ff @(posedge clk) begin
        if (rst) begin
            lamp_r <= 3'h0;
            temp_r <= 8'h00;
            age_r  <= 4'h0;
        end else begin
            if (lamp_wr) lamp_r <= avs_writedata[2:0];
            if (wr_ok && avs_address == REG_TEMP_CTRL) temp_r <= avs_writedata[7:0];
            age_r <= lamp_wr ? 4'h0 : (age_r == 4'hF ? age_r : age_r + 4'h1);
        end
    end
    // Edges right after a status change are excluded by the age guard
    always_ff @(posedge clk) begin
        prev_r <= rst ? 1'b1 : ind;
        run_r  <= rst ? 32'h0 : (ind != prev_r ? 32'h1 : run_r + 32'h1);
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not one cycle after request");
    a_fast_lit_len: assert property ($rose(ind) && fast && age_r > 4'h4 |-> run_r == 32'(FAST_ON))
        else $error("fast lit time wrong");
    a_fast_dark_len: assert property ($fell(ind) && fast && age_r > 4'h4 |-> run_r == 32'(FAST_PERIOD - FAST_ON))
        else $error("fast dark time wrong");
    a_slow_lit_len: assert property ($rose(ind) && slow && age_r > 4'h4 |-> run_r == 32'(SLOW_ON))
        else $error("slow lit time wrong");
    a_slow_dark_len: assert property ($fell(ind) && slow && age_r > 4'h4 |-> run_r == 32'(SLOW_PERIOD - SLOW_ON))
        else $error("slow dark time wrong");
    a_call_lamp_lit: assert property (lamp_r[2] && age_r > 4'h4 |-> !ind)
        else $error("lamp not lit during call");
    a_off_lamp_dark: assert property (dark && age_r > 4'h4 |-> ind)
        else $error("lamp not dark while off");
    a_restart_lit: assert property (lamp_wr && (avs_writedata[2] || ^avs_writedata[1:0]) |-> ##[1:4] !ind)
        else $error("pattern did not restart lit");
    a_alarm_pad_high: assert property ((temp_r[0] && temp_r[7:4] < 4'hA && temp_limit_reached) [*5]
        |-> pad_oe[temp_r[7:4]] && pad_out[temp_r[7:4]])
        else $error("alarm pad not driven high");
endmodule
bind gpio_status_top gpio_status_properties #(.FAST_PERIOD(FAST_PERIOD), .FAST_ON(FAST_ON),
    .SLOW_PERIOD(SLOW_PERIOD), .SLOW_ON(SLOW_ON)) gpio_status_properties_i (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .pad_out(pad_out), .pad_oe(pad_oe),
    .temp_limit_reached(temp_limit_reached), .network_status_indicator(network_status_indicator));
`default_nettype wire

// >>> bench/gpio_with_status_indicator_bench.sv
// Testbench: register access, pad modes, alarm, interrupt and lamp patterns
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module gpio_with_status_indicator_bench
    import gpio_status_pkg::*;
;
    localparam longint FP = 10;
    localparam longint FO = 5;
    localparam longint SP = 30;
    localparam longint SO = 3;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic [ADDR_W-1:0]    avs_address = '0;
    logic                 avs_read = 1'b0;
    logic                 avs_write = 1'b0;
    logic [31:0]          avs_writedata = '0;
    logic [31:0]          avs_readdata;
    logic                 avs_waitrequest;
    logic [PAD_COUNT-1:0] pad_in;
    logic [PAD_COUNT-1:0] pad_out;
    logic [PAD_COUNT-1:0] pad_oe;
    logic [PAD_COUNT-1:0] ext_en = '0;
    logic [PAD_COUNT-1:0] ext_val = '0;
    logic                 temp_limit_reached = 1'b0;
    logic                 network_status_indicator;
    logic                 irq;
    logic                 lamp_lit;
    logic [31:0]          rd;
    int                   n_errors = 0;
    int                   comparisons = 0;
    int                   cycles = 0;

    always #5 clk = ~clk;

    gpio_status_top #(.FAST_PERIOD(FP), .FAST_ON(FO), .SLOW_PERIOD(SP), .SLOW_ON(SO)) gpio_status_top_i (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .temp_limit_reached(temp_limit_reached), .network_status_indicator(network_status_indicator), .irq(irq));
    pad_partner pad_partner_i (.pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en), .ext_val(ext_val),
        .network_status_indicator(network_status_indicator), .pad_in(pad_in), .lamp_lit(lamp_lit));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic results();
        if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Request is held until the edge where waitrequest is seen low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        forever begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // Counting over 30 cycles covers whole periods of both blink rates
    task automatic lamp_case(input logic [31:0] code, input int exp);
        int lit;
        bus(1'b1, REG_LAMP_CTRL, code);
        tick(3);
        `CHK(lamp_lit, 1'(exp != 0))
        lit = 0;
        repeat (30) begin
            tick(1);
            lit += int'(lamp_lit === 1'b1);
        end
        `CHK(lit, exp)
        bus(1'b1, REG_LAMP_CTRL, 32'h0);
        tick(4);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, REG_MODE_LO, 32'h0); `CHK(rd, MODE_RESET)
        bus(1'b0, REG_OUT_DATA, 32'h0); `CHK(rd, OUT_RESET)
        bus(1'b0, REG_IRQ_EN, 32'h0); `CHK(rd, IRQ_EN_RESET)
        bus(1'b0, 4'hF, 32'h0); `CHK(rd, 32'h0)
        `CHK(pad_oe, 10'h000)
        // Pad 0 output, pad 1 alternate, pad 2 input, pad 8 output
        bus(1'b1, REG_MODE_LO, 32'h0000_0009);
        bus(1'b1, REG_MODE_HI, 32'h0000_0001);
        bus(1'b1, REG_ALT_DATA, 32'h0000_0002);
        bus(1'b1, REG_OUT_DATA, 32'h0000_0101);
        tick(2);
        `CHK(pad_oe[2:0], 3'b011)
        `CHK(pad_out[1:0], 2'b11)
        `CHK(pad_in[8], 1'b1)
        bus(1'b0, REG_OUT_DATA, 32'h0); `CHK(rd[9:0], 10'h101)
        bus(1'b1, REG_OUT_DATA, 32'h0000_0002);
        tick(2);
        `CHK(pad_out[1:0], 2'b10)
        `CHK(pad_oe[1:0], 2'b11)
        @(posedge clk);
        ext_en <= 10'h004;
        ext_val <= 10'h004;
        tick(4);
        bus(1'b0, REG_IN_DATA, 32'h0); `CHK(rd[2], 1'b1)
        bus(1'b1, REG_IN_DATA, 32'h0);
        bus(1'b0, REG_IN_DATA, 32'h0); `CHK(rd[2], 1'b1)
        `CHK(pad_oe[2], 1'b0)
        // Input change event: masked, enabled, cleared
        bus(1'b0, REG_IRQ_STAT, 32'h0); `CHK(rd[IRQ_INPUT_BIT], 1'b1)
        `CHK(irq, 1'b0)
        bus(1'b1, REG_IRQ_EN, 32'h2); tick(2); `CHK(irq, 1'b1)
        bus(1'b1, REG_IRQ_CLR, 32'h2); tick(2); `CHK(irq, 1'b0)
        bus(1'b0, REG_IRQ_STAT, 32'h0); `CHK(rd[IRQ_INPUT_BIT], 1'b0)
        // Alarm on pad 3, which is in input mode
        bus(1'b1, REG_TEMP_CTRL, 32'h31);
        @(posedge clk);
        temp_limit_reached <= 1'b1;
        tick(5);
        `CHK(pad_oe[3], 1'b1)
        `CHK(pad_in[3], 1'b1)
        bus(1'b0, REG_STATUS, 32'h0); `CHK(rd[1:0], 2'b11)
        bus(1'b0, REG_IRQ_STAT, 32'h0); `CHK(rd[IRQ_TEMP_BIT], 1'b1)
        bus(1'b1, REG_TEMP_CTRL, 32'h30); tick(2); `CHK(pad_oe[3], 1'b0)
        @(posedge clk);
        temp_limit_reached <= 1'b0;
        lamp_case(32'h1, int'(30 / FP * FO));
        lamp_case(32'h2, int'(30 / SP * SO));
        lamp_case(32'h6, 30);
        lamp_case(32'h5, 30);
        lamp_case(32'h0, 0);
        lamp_case(32'h3, 0);
        bus(1'b0, REG_IRQ_STAT, 32'h0); `CHK(rd[IRQ_LAMP_BIT], 1'b1)
        results();
    end
endmodule
`default_nettype wire

// >>> bench/pad_partner.sv
// External pad devices and lamp driver transistor
`timescale 1ns/1ps
`default_nettype none
module pad_partner
    import gpio_status_pkg::*;
(
    input  wire logic [PAD_COUNT-1:0] pad_out,
    input  wire logic [PAD_COUNT-1:0] pad_oe,
    input  wire logic [PAD_COUNT-1:0] ext_en,
    input  wire logic [PAD_COUNT-1:0] ext_val,
    input  wire logic                 network_status_indicator,
    output logic      [PAD_COUNT-1:0] pad_in,
    output logic                      lamp_lit
);
    // Pads have pull-downs, so a high level only comes from a driver
    always_comb pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val);
    // Transistor inverts the pin
    always_comb lamp_lit = !network_status_indicator;
endmodule
`default_nettype wire

// >>> design/gpio_status_top.sv
// Ten-pad configurable GPIO bank with over-temperature alarm and status lamp
//
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module gpio_status_top
    import gpio_status_pkg::*;
#(
    parameter longint FAST_PERIOD = FAST_PERIOD_CYC,
    parameter longint FAST_ON     = FAST_ON_CYC,
    parameter longint SLOW_PERIOD = SLOW_PERIOD_CYC,
    parameter longint SLOW_ON     = SLOW_ON_CYC
)
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic [ADDR_W-1:0]    avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    input  wire logic [PAD_COUNT-1:0] pad_in,
    output logic [PAD_COUNT-1:0]      pad_out,
    output logic [PAD_COUNT-1:0]      pad_oe,
    input  wire logic                 temp_limit_reached,
    output logic                      network_status_indicator,
    output logic                      irq
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [2*PAD_COUNT-1:0] mode_r;
    logic [PAD_COUNT-1:0]   out_data_r;
    logic [PAD_COUNT-1:0]   alt_data_r;
    logic [7:0]             over_temperature_alarm_setup_r;
    logic [2:0]             lamp_ctrl_r;
    logic [IRQ_W-1:0]       irq_stat_r;
    logic [IRQ_W-1:0]       irq_en_r;
    logic                   ack_r;
    logic                   temp_meta_r;
    logic                   temp_sync_r;
    logic                   temp_prev_r;
    logic [PAD_COUNT-1:0]   in_prev_r;

    logic [PAD_COUNT-1:0]   level;
    logic [PAD_COUNT-1:0]   alt_drive;
    logic [31:0]            wmask;
    logic [31:0]            rdata;
    logic                   wr_en;
    logic                   rd_en;
    logic                   temp_alarm;
    logic [TEMP_PAD_W-1:0]  alarm_pad;
    logic                   lamp_restart;
    logic [IRQ_W-1:0]       irq_events;
    logic [PAD_COUNT-1:0]   in_change;

    // ------------------------------------------------------------
    // Avalon slave: one wait state, then the answer
    // ------------------------------------------------------------
    // A single wait cycle lets read data come out of a flop
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign wr_en           = avs_write & ack_r;
    assign rd_en           = avs_read & ~ack_r;

    always_ff @(posedge clk) begin
        if (rst)
            ack_r <= 1'b0;
        else
            ack_r <= (avs_read | avs_write) & ~ack_r;
    end

    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            assign wmask[8*b +: 8] = {8{avs_byteenable[b]}};
        end
    endgenerate

    // ------------------------------------------------------------
    // Software-written state
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_r <= MODE_RESET[2*PAD_COUNT-1:0];
        end else if (wr_en && avs_address == REG_MODE_LO) begin
            mode_r[15:0] <= (mode_r[15:0] & ~wmask[15:0]) | (avs_writedata[15:0] & wmask[15:0]);
        end else if (wr_en && avs_address == REG_MODE_HI) begin
            mode_r[19:16] <= (mode_r[19:16] & ~wmask[3:0]) | (avs_writedata[3:0] & wmask[3:0]);
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            out_data_r <= OUT_RESET[PAD_COUNT-1:0];
        else if (wr_en && avs_address == REG_OUT_DATA)
            out_data_r <= (out_data_r & ~wmask[PAD_COUNT-1:0])
                        | (avs_writedata[PAD_COUNT-1:0] & wmask[PAD_COUNT-1:0]);
    end

    // Firmware-side value for alternate pads
    always_ff @(posedge clk) begin
        if (rst)
            alt_data_r <= OUT_RESET[PAD_COUNT-1:0];
        else if (wr_en && avs_address == REG_ALT_DATA)
            alt_data_r <= (alt_data_r & ~wmask[PAD_COUNT-1:0])
                        | (avs_writedata[PAD_COUNT-1:0] & wmask[PAD_COUNT-1:0]);
    end

    always_ff @(posedge clk) begin
        if (rst)
            over_temperature_alarm_setup_r <= TEMP_RESET[7:0];
        else if (wr_en && avs_address == REG_TEMP_CTRL && avs_byteenable[0])
            over_temperature_alarm_setup_r <= avs_writedata[7:0];
    end

    always_ff @(posedge clk) begin
        if (rst)
            lamp_ctrl_r <= LAMP_RESET[2:0];
        else if (wr_en && avs_address == REG_LAMP_CTRL && avs_byteenable[0])
            lamp_ctrl_r <= avs_writedata[2:0];
    end

    always_ff @(posedge clk) begin
        if (rst)
            irq_en_r <= IRQ_EN_RESET[IRQ_W-1:0];
        else if (wr_en && avs_address == REG_IRQ_EN && avs_byteenable[0])
            irq_en_r <= avs_writedata[IRQ_W-1:0];
    end

    // ------------------------------------------------------------
    // Over-temperature alarm
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            temp_meta_r <= 1'b0;
            temp_sync_r <= 1'b0;
            temp_prev_r <= 1'b0;
        end else begin
            temp_meta_r <= temp_limit_reached;
            temp_sync_r <= temp_meta_r;
            temp_prev_r <= temp_alarm;
        end
    end

    assign alarm_pad  = over_temperature_alarm_setup_r[TEMP_PAD_LSB +: TEMP_PAD_W];
    assign temp_alarm = over_temperature_alarm_setup_r[TEMP_EN_BIT] & temp_sync_r;

    // ------------------------------------------------------------
    // Pad cells
    // ------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < PAD_COUNT; p++) begin : g_pad
            logic [1:0] eff_mode;
            // Alarm takes the selected pad over whatever mode it had
            assign alt_drive[p] = (temp_alarm && alarm_pad == TEMP_PAD_W'(p)) ? 1'b1 : alt_data_r[p];
            assign eff_mode     = (temp_alarm && alarm_pad == TEMP_PAD_W'(p)) ? MODE_ALT : mode_r[2*p +: 2];
            pad_cell u_pad (
                .clk       (clk),
                .rst       (rst),
                .mode      (eff_mode),
                .out_value (out_data_r[p]),
                .alt_value (alt_drive[p]),
                .pad_in    (pad_in[p]),
                .pad_out   (pad_out[p]),
                .pad_oe    (pad_oe[p]),
                .level     (level[p])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Status indicator
    // ------------------------------------------------------------
    lamp_blinker #(
        .FAST_PERIOD (FAST_PERIOD),
        .FAST_ON     (FAST_ON),
        .SLOW_PERIOD (SLOW_PERIOD),
        .SLOW_ON     (SLOW_ON)
    ) u_lamp (
        .clk           (clk),
        .rst           (rst),
        .net_state     (lamp_ctrl_r[LAMP_STATE_LSB +: LAMP_STATE_W]),
        .call_active   (lamp_ctrl_r[LAMP_CALL_BIT]),
        .indicator_pin (network_status_indicator),
        .restarted     (lamp_restart)
    );

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst)
            in_prev_r <= '0;
        else
            in_prev_r <= level;
    end

    always_comb begin
        for (int i = 0; i < PAD_COUNT; i++)
            in_change[i] = (mode_r[2*i +: 2] == MODE_INPUT) && (level[i] != in_prev_r[i]);
    end

    assign irq_events[IRQ_TEMP_BIT]  = temp_alarm & ~temp_prev_r;
    assign irq_events[IRQ_INPUT_BIT] = |in_change;
    assign irq_events[IRQ_LAMP_BIT]  = lamp_restart;

    // New event wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst)
            irq_stat_r <= '0;
        else if (wr_en && avs_address == REG_IRQ_CLR && avs_byteenable[0])
            irq_stat_r <= (irq_stat_r & ~avs_writedata[IRQ_W-1:0]) | irq_events;
        else
            irq_stat_r <= irq_stat_r | irq_events;
    end

    always_ff @(posedge clk) begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_r & irq_en_r);
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rdata = 32'h0000_0000;
        case (avs_address)
            REG_MODE_LO:   rdata[15:0] = mode_r[15:0];
            REG_MODE_HI:   rdata[3:0] = mode_r[19:16];
            REG_OUT_DATA:  rdata[PAD_COUNT-1:0] = out_data_r;
            REG_IN_DATA:   rdata[PAD_COUNT-1:0] = level;
            REG_ALT_DATA:  rdata[PAD_COUNT-1:0] = alt_data_r;
            REG_TEMP_CTRL: rdata[7:0] = over_temperature_alarm_setup_r;
            REG_LAMP_CTRL: rdata[2:0] = lamp_ctrl_r;
            REG_IRQ_STAT:  rdata[IRQ_W-1:0] = irq_stat_r;
            REG_IRQ_EN:    rdata[IRQ_W-1:0] = irq_en_r;
            REG_STATUS:    rdata[1:0] = {network_status_indicator, temp_alarm};
            default:       rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst)
            avs_readdata <= 32'h0000_0000;
        else if (rd_en)
            avs_readdata <= rdata;
    end

endmodule
`default_nettype wire

// >>> design/lamp_blinker.sv
// Status lamp pattern generator with inverted pin polarity
`timescale 1ns/1ps
`default_nettype none
module lamp_blinker
    import gpio_status_pkg::*;
#(
    parameter longint FAST_PERIOD = FAST_PERIOD_CYC,
    parameter longint FAST_ON     = FAST_ON_CYC,
    parameter longint SLOW_PERIOD = SLOW_PERIOD_CYC,
    parameter longint SLOW_ON     = SLOW_ON_CYC
)
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] net_state,
    input  wire logic       call_active,
    output logic            indicator_pin,
    output logic            restarted
);

    typedef enum logic [1:0] {PAT_DARK, PAT_FAST, PAT_SLOW, PAT_LIT} pattern_t;

    pattern_t               pattern;
    pattern_t               pattern_r;
    logic [BLINK_CNT_W-1:0] cnt_r;
    logic [BLINK_CNT_W-1:0] period;
    logic [BLINK_CNT_W-1:0] on_time;
    logic                   lamp_on;

    always_comb begin
        if (call_active)
            pattern = PAT_LIT;
        else begin
            case (net_state)
                LAMP_SEARCHING:  pattern = PAT_FAST;
                LAMP_REGISTERED: pattern = PAT_SLOW;
                default:         pattern = PAT_DARK;
            endcase
        end
    end

    always_comb begin
        case (pattern_r)
            PAT_FAST: begin
                period  = BLINK_CNT_W'(FAST_PERIOD);
                on_time = BLINK_CNT_W'(FAST_ON);
            end
            default: begin
                period  = BLINK_CNT_W'(SLOW_PERIOD);
                on_time = BLINK_CNT_W'(SLOW_ON);
            end
        endcase
    end

    assign restarted = (pattern != pattern_r);

    // Pattern restarts from cycle zero on any change, lit unless the new one is PAT_DARK
    always_ff @(posedge clk) begin
        if (rst) begin
            pattern_r <= PAT_DARK;
            cnt_r     <= '0;
        end else if (restarted) begin
            pattern_r <= pattern;
            cnt_r     <= '0;
        end else if (cnt_r == period - 1'b1) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_comb begin
        case (pattern_r)
            PAT_LIT:  lamp_on = 1'b1;
            PAT_FAST: lamp_on = (cnt_r < on_time);
            PAT_SLOW: lamp_on = (cnt_r < on_time);
            default:  lamp_on = 1'b0;
        endcase
    end

    // External transistor inverts, so lit means pin low
    always_ff @(posedge clk) begin
        if (rst)
            indicator_pin <= 1'b1;
        else
            indicator_pin <= ~lamp_on;
    end

endmodule
`default_nettype wire

// >>> design/pad_cell.sv
// One configurable pad: input sampling and push-pull drive selection
`timescale 1ns/1ps
`default_nettype none
module pad_cell
    import gpio_status_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [1:0] mode,
    input  wire logic       out_value,
    input  wire logic       alt_value,
    input  wire logic       pad_in,
    output logic            pad_out,
    output logic            pad_oe,
    output logic            level
);

    logic meta_r;
    logic sync_r;

    // Two stages; only the second is looked at
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= pad_in;
            sync_r <= meta_r;
        end
    end

    assign level = sync_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            pad_out <= 1'b0;
            pad_oe  <= 1'b0;
        end else begin
            case (mode)
                MODE_OUTPUT: begin
                    pad_out <= out_value;
                    pad_oe  <= 1'b1;
                end
                MODE_ALT: begin
                    pad_out <= alt_value;
                    pad_oe  <= 1'b1;
                end
                default: begin
                    pad_out <= 1'b0;
                    pad_oe  <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> pkg/gpio_status_pkg.sv
// Package: register map, field layout, reset values and timing counts of the pad bank
package gpio_status_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int unsigned PAD_COUNT   = 10;
    localparam int unsigned ADDR_W      = 4;

    // ------------------------------------------------------------
    // Register word indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_MODE_LO   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_MODE_HI   = 4'h1;
    localparam logic [ADDR_W-1:0] REG_OUT_DATA  = 4'h2;
    localparam logic [ADDR_W-1:0] REG_IN_DATA   = 4'h3;
    localparam logic [ADDR_W-1:0] REG_ALT_DATA  = 4'h4;
    localparam logic [ADDR_W-1:0] REG_TEMP_CTRL = 4'h5;
    localparam logic [ADDR_W-1:0] REG_LAMP_CTRL = 4'h6;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT  = 4'h7;
    localparam logic [ADDR_W-1:0] REG_IRQ_EN    = 4'h8;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLR   = 4'h9;
    localparam logic [ADDR_W-1:0] REG_STATUS    = 4'hA;

    // ------------------------------------------------------------
    // Pad modes, two bits per pad
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_INPUT  = 2'h0;
    localparam logic [1:0] MODE_OUTPUT = 2'h1;
    localparam logic [1:0] MODE_ALT    = 2'h2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned TEMP_EN_BIT    = 0;
    localparam int unsigned TEMP_PAD_LSB   = 4;
    localparam int unsigned TEMP_PAD_W     = 4;
    localparam int unsigned LAMP_STATE_LSB = 0;
    localparam int unsigned LAMP_STATE_W   = 2;
    localparam int unsigned LAMP_CALL_BIT  = 2;
    localparam int unsigned IRQ_W          = 3;
    localparam int unsigned IRQ_TEMP_BIT   = 0;
    localparam int unsigned IRQ_INPUT_BIT  = 1;
    localparam int unsigned IRQ_LAMP_BIT   = 2;

    // ------------------------------------------------------------
    // Indicator status codes
    // ------------------------------------------------------------
    localparam logic [1:0] LAMP_OFF        = 2'h0;
    localparam logic [1:0] LAMP_SEARCHING  = 2'h1;
    localparam logic [1:0] LAMP_REGISTERED = 2'h2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] MODE_RESET     = 32'h0000_0000;
    localparam logic [31:0] OUT_RESET      = 32'h0000_0000;
    localparam logic [31:0] TEMP_RESET     = 32'h0000_0000;
    localparam logic [31:0] LAMP_RESET     = 32'h0000_0000;
    localparam logic [31:0] IRQ_EN_RESET   = 32'h0000_0000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ            = 100_000_000;
    localparam longint FAST_PERIOD_MS    = 1000;
    localparam longint FAST_ON_MS        = 500;
    localparam longint SLOW_PERIOD_MS    = 3000;
    localparam longint SLOW_ON_MS        = 300;
    localparam longint FAST_PERIOD_CYC   = FAST_PERIOD_MS * CLK_HZ / 1000;
    localparam longint FAST_ON_CYC       = FAST_ON_MS * CLK_HZ / 1000;
    localparam longint SLOW_PERIOD_CYC   = SLOW_PERIOD_MS * CLK_HZ / 1000;
    localparam longint SLOW_ON_CYC       = SLOW_ON_MS * CLK_HZ / 1000;
    localparam int unsigned BLINK_CNT_W  = 32;

endpackage
